// file: design/quad_timer.sv
`timescale 1ns/1ps
module quad_timer
   import quad_timer_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Register port
   input  wire logic [ADDR_W-1:0]       addr,
   input  wire logic [DATA_W-1:0]       wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [DATA_W-1:0]       rdata,
   output logic                         irq,
   // Timer pins
   input  wire logic                    timer_one_input,
   input  wire logic                    timer_two_input,
   input  wire logic                    timer_three_input,
   input  wire logic                    timer_four_input,
   input  wire logic                    gate_a_pin,
   input  wire logic                    gate_b_pin,
   output logic                         timer_one_output,
   output logic                         timer_two_output,
   output logic                         timer_three_output,
   output logic                         timer_four_output,
   // Clock pins
   input  wire logic [NUM_CLK_PINS-1:0] ext_clock_pins,
   input  wire logic                    dedicated_timer_clock_pin,
   output logic      [NUM_BRG-1:0]      rate_gen_out,
   output logic      [NUM_BRG-1:0]      rate_gen_oe
);

   localparam int NT = NUM_TIMERS;
   localparam int NB = NUM_BRG;
   localparam int NC = NUM_CLK_PINS;

   typedef struct packed {
      logic [DATA_W-1:0]                ctrl;
      logic [DATA_W-1:0]                mask;
      logic [DATA_W-1:0]                stat;
      logic [DATA_W-1:0]                siu_cnt;
      logic [DATA_W-1:0]                rdata;
      logic [NT-1:0][DATA_W-1:0]        mode;
      logic [NT-1:0][DATA_W-1:0]        ref_val;
      logic [NT-1:0][DATA_W-1:0]        cnt;
      logic [NT-1:0][DATA_W-1:0]        cap;
      logic [NB-1:0][DATA_W-1:0]        brg_cfg;
      logic [NB-1:0][BRG_DIV_W-1:0]     brg_cnt;
      logic [NB-1:0]                    brg_out;
      logic [NT-1:0]                    tout;
      logic [NT-1:0]                    match_q;
      logic [PRE_W-1:0]                 pre;
      logic [NT-1:0]                    tin_s1;
      logic [NT-1:0]                    tin_s2;
      logic [NT-1:0]                    tin_d;
      logic [1:0]                       gate_s1;
      logic [1:0]                       gate_s2;
      logic [1:0]                       gate_d;
      logic [NC-1:0]                    clk_s1;
      logic [NC-1:0]                    clk_s2;
      logic [NC-1:0]                    clk_d;
      logic                             tm_s1;
      logic                             tm_s2;
      logic                             tm_d;
      logic                             irq;
   } state_t;

   localparam state_t STATE_RST = '{tout: '1, default: '0};

   state_t state_reg;
   state_t state_next;

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      logic [NT-1:0]        tin_rise;
      logic [NT-1:0]        tin_fall;
      logic [1:0]           gate_fall;
      logic [NC-1:0]        clk_rise;
      logic                 pre_tick;
      logic [NB-1:0]        brg_tick;
      logic                 brg_en;
      logic [3:0]           brg_src;
      logic                 siu_tick;
      logic [NT-1:0]        match;
      logic [NT-1:0]        capt;
      logic                 t_tick;
      logic                 gated;
      logic                 gate_ok;
      logic [DATA_W-1:0]    clr;
      logic [1:0]           tidx;
      logic [2:0]           bidx;
      tin_rise  = '0;
      tin_fall  = '0;
      gate_fall = '0;
      clk_rise  = '0;
      pre_tick  = 1'b0;
      brg_tick  = '0;
      brg_en    = 1'b0;
      brg_src   = '0;
      siu_tick  = 1'b0;
      match     = '0;
      capt      = '0;
      t_tick    = 1'b0;
      gated     = 1'b0;
      gate_ok   = 1'b0;
      clr       = '0;
      tidx      = addr[3:2];
      bidx      = addr[4:2];
      state_next = state_reg;

      // Pin synchronisers and edge detectors
      state_next.tin_s1  = {timer_four_input, timer_three_input, timer_two_input, timer_one_input};
      state_next.tin_s2  = state_reg.tin_s1;
      state_next.tin_d   = state_reg.tin_s2;
      state_next.gate_s1 = {gate_b_pin, gate_a_pin};
      state_next.gate_s2 = state_reg.gate_s1;
      state_next.gate_d  = state_reg.gate_s2;
      state_next.clk_s1  = ext_clock_pins;
      state_next.clk_s2  = state_reg.clk_s1;
      state_next.clk_d   = state_reg.clk_s2;
      state_next.tm_s1   = dedicated_timer_clock_pin;
      state_next.tm_s2   = state_reg.tm_s1;
      state_next.tm_d    = state_reg.tm_s2;
      tin_rise  = state_reg.tin_s2 & ~state_reg.tin_d;
      tin_fall  = ~state_reg.tin_s2 & state_reg.tin_d;
      gate_fall = ~state_reg.gate_s2 & state_reg.gate_d;
      clk_rise  = state_reg.clk_s2 & ~state_reg.clk_d;

      // Divide by sixteen prescaler
      state_next.pre = state_reg.pre + 4'h1;
      pre_tick = (state_reg.pre == PRE_LAST);

      // ***********************************************************
      // Rate generators
      // ***********************************************************
      for (int b = 0; b < NB; b++) begin
         brg_src = state_reg.brg_cfg[b][BRG_SRC_LSB +: 4];
         if (b == 0) begin
            if (state_reg.ctrl[CTRL_EXT_CLOCK_FIVE_EN]) begin
               brg_en = clk_rise[EXT_CLOCK_FIVE_IDX];
            end else begin
               brg_en = 1'b1;
            end
         end else if (brg_src != 4'h0 && brg_src <= 4'(NC)) begin
            brg_en = clk_rise[brg_src - 4'h1];
         end else begin
            brg_en = 1'b1;
         end
         if (brg_en) begin
            if (state_reg.brg_cnt[b] == state_reg.brg_cfg[b][BRG_DIV_W-1:0]) begin
               state_next.brg_cnt[b] = '0;
               state_next.brg_out[b] = ~state_reg.brg_out[b];
               brg_tick[b] = 1'b1;
            end else begin
               state_next.brg_cnt[b] = state_reg.brg_cnt[b] + 12'h1;
            end
         end
      end

      // System unit timer clock
      if (state_reg.ctrl[CTRL_DEDICATED_TIMER_CLOCK_PIN_EN]) begin
         siu_tick = state_reg.tm_s2 & ~state_reg.tm_d;
      end else begin
         siu_tick = brg_tick[0];
      end
      if (siu_tick) begin
         state_next.siu_cnt = state_reg.siu_cnt + 16'h1;
      end

      // ***********************************************************
      // Timers
      // ***********************************************************
      for (int i = 0; i < NT; i++) begin
         case (state_reg.mode[i][MODE_SRC_LSB +: 2])
            SRC_CASCADE: t_tick = state_reg.match_q[(i + NT - 1) % NT];
            SRC_SYS:     t_tick = 1'b1;
            SRC_SYS16:   t_tick = pre_tick;
            SRC_PIN:     t_tick = tin_rise[i];
            default:     t_tick = 1'b0;
         endcase
         gated   = state_reg.ctrl[CTRL_GATE_LSB + i];
         gate_ok = ~gated | ~state_reg.gate_s2[i / 2];
         if (gated && state_reg.mode[i][MODE_RESTART] && gate_fall[i / 2]) begin
            state_next.cnt[i] = '0;
         end else if (state_reg.mode[i][MODE_RUN] && gate_ok && t_tick) begin
            if (state_reg.cnt[i] == state_reg.ref_val[i]) begin
               state_next.cnt[i] = '0;
               match[i] = 1'b1;
            end else begin
               state_next.cnt[i] = state_reg.cnt[i] + 16'h1;
            end
         end
         // Output pin
         if (state_reg.mode[i][MODE_TOGGLE]) begin
            if (match[i] && state_reg.mode[i][MODE_OUT_EN]) begin
               state_next.tout[i] = ~state_reg.tout[i];
            end
         end else begin
            state_next.tout[i] = ~(match[i] & state_reg.mode[i][MODE_OUT_EN]);
         end
         // Capture on selected edges
         capt[i] = (tin_rise[i] & state_reg.mode[i][MODE_CAP_R])
                 | (tin_fall[i] & state_reg.mode[i][MODE_CAP_F]);
         if (capt[i]) begin
            state_next.cap[i] = state_reg.cnt[i];
         end
      end
      state_next.match_q = match;

      // ***********************************************************
      // Register port
      // ***********************************************************
      state_next.rdata = '0;
      if (rd) begin
         if (addr == CTRL_OFS) begin
            state_next.rdata = state_reg.ctrl;
         end else if (addr == STAT_OFS) begin
            state_next.rdata = state_reg.stat;
            clr = state_reg.stat;
         end else if (addr == MASK_OFS) begin
            state_next.rdata = state_reg.mask;
         end else if (addr == SIUCNT_OFS) begin
            state_next.rdata = state_reg.siu_cnt;
         end else if (addr[7:4] == TMODE_OFS[7:4]) begin
            state_next.rdata = state_reg.mode[tidx];
         end else if (addr[7:4] == TREF_OFS[7:4]) begin
            state_next.rdata = state_reg.ref_val[tidx];
         end else if (addr[7:4] == TCNT_OFS[7:4]) begin
            state_next.rdata = state_reg.cnt[tidx];
         end else if (addr[7:4] == TCAP_OFS[7:4]) begin
            state_next.rdata = state_reg.cap[tidx];
         end else if (addr[7:5] == BRG_OFS[7:5]) begin
            state_next.rdata = state_reg.brg_cfg[bidx];
         end
      end
      if (wr) begin
         if (addr == CTRL_OFS) begin
            state_next.ctrl = wdata;
         end else if (addr == MASK_OFS) begin
            state_next.mask = wdata;
         end else if (addr[7:4] == TMODE_OFS[7:4]) begin
            state_next.mode[tidx] = wdata;
         end else if (addr[7:4] == TREF_OFS[7:4]) begin
            state_next.ref_val[tidx] = wdata;
         end else if (addr[7:5] == BRG_OFS[7:5]) begin
            state_next.brg_cfg[bidx] = wdata;
         end
      end

      // Sticky status, set wins over read clear
      state_next.stat = state_reg.stat & ~clr;
      state_next.stat[STAT_MATCH_LSB +: NT] = state_next.stat[STAT_MATCH_LSB +: NT] | match;
      state_next.stat[STAT_CAP_LSB +: NT] = state_next.stat[STAT_CAP_LSB +: NT] | capt;
      state_next.irq = |(state_next.stat & state_next.mask);
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata              = state_reg.rdata;
   assign irq                = state_reg.irq;
   assign timer_one_output   = state_reg.tout[0];
   assign timer_two_output   = state_reg.tout[1];
   assign timer_three_output = state_reg.tout[2];
   assign timer_four_output  = state_reg.tout[3];
   assign rate_gen_out       = state_reg.brg_out;
   assign rate_gen_oe        = state_reg.ctrl[CTRL_BRG_OE +: NB];

endmodule : quad_timer

// file: design/quad_timer_pkg.sv
package quad_timer_pkg;
   // Sizes
   localparam int NUM_TIMERS   = 4;
   localparam int NUM_BRG      = 8;
   localparam int NUM_CLK_PINS = 10;
   localparam int DATA_W       = 16;
   localparam int ADDR_W       = 8;
   localparam int BRG_DIV_W    = 12;
   localparam int PRE_W        = 4;
   // System clock divided by sixteen
   localparam logic [PRE_W-1:0] PRE_LAST = 4'hf;
   // Index of the fifth external clock pin
   localparam logic [3:0] EXT_CLOCK_FIVE_IDX = 4'h4;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h08;
   localparam logic [ADDR_W-1:0] MASK_OFS   = 8'h0c;
   localparam logic [ADDR_W-1:0] SIUCNT_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] TMODE_OFS  = 8'h20;
   localparam logic [ADDR_W-1:0] TREF_OFS   = 8'h30;
   localparam logic [ADDR_W-1:0] TCNT_OFS   = 8'h40;
   localparam logic [ADDR_W-1:0] TCAP_OFS   = 8'h50;
   localparam logic [ADDR_W-1:0] BRG_OFS    = 8'h60;

   // Control register fields
   localparam int CTRL_EXT_CLOCK_FIVE_EN  = 0;
   localparam int CTRL_DEDICATED_TIMER_CLOCK_PIN_EN = 1;
   localparam int CTRL_GATE_LSB = 2;
   localparam int CTRL_BRG_OE   = 8;

   // Timer mode register fields
   localparam int MODE_SRC_LSB = 0;
   localparam int MODE_TOGGLE  = 2;
   localparam int MODE_OUT_EN  = 3;
   localparam int MODE_CAP_R   = 4;
   localparam int MODE_CAP_F   = 5;
   localparam int MODE_RESTART = 6;
   localparam int MODE_RUN     = 7;

   // Status register fields
   localparam int STAT_MATCH_LSB = 0;
   localparam int STAT_CAP_LSB   = 4;

   // Rate generator config fields
   localparam int BRG_SRC_LSB = 12;

   // Timer count sources
   localparam logic [1:0] SRC_CASCADE = 2'h0;
   localparam logic [1:0] SRC_SYS     = 2'h1;
   localparam logic [1:0] SRC_SYS16   = 2'h2;
   localparam logic [1:0] SRC_PIN     = 2'h3;
endpackage : quad_timer_pkg

// file: tb/ext_clock_source.sv
`timescale 1ns/1ps
// ********************************************
// External clock pins, still while not running
// ********************************************
module ext_clock_source (
   // System clock
   input  wire logic        clk,
   // Run enables, bit 10 is the timer clock pin
   input  wire logic [10:0] run,
   // Pins
   output logic      [9:0]  ext_clock_pins,
   output logic             dedicated_timer_clock_pin
);
   logic [1:0] div_reg = 2'h0;

   initial begin
      ext_clock_pins = 10'h0;
      dedicated_timer_clock_pin = 1'b0;
   end

   // Period of eight system clocks
   always @(posedge clk) begin
      div_reg <= div_reg + 2'h1;
      for (int i = 0; i < 10; i++) ext_clock_pins[i] <= run[i] & (ext_clock_pins[i] ^ (div_reg == 2'h3));
      dedicated_timer_clock_pin <= run[10] & (dedicated_timer_clock_pin ^ (div_reg == 2'h3));
   end
endmodule : ext_clock_source

// file: tb/quad_timer_monitor.sv
`timescale 1ns/1ps
// ************
// Port checker
// ************
module quad_timer_monitor
   import quad_timer_pkg::*;
(
   // Clock and reset
   input wire logic                clk,
   input wire logic                rst,
   // Register port
   input wire logic [ADDR_W-1:0]   addr,
   input wire logic [DATA_W-1:0]   wdata,
   input wire logic                wr,
   input wire logic                rd,
   input wire logic [DATA_W-1:0]   rdata,
   input wire logic                irq,
   // Pins
   input wire logic                gate_a_pin,
   input wire logic                gate_b_pin,
   input wire logic                timer_one_output,
   input wire logic                timer_three_output,
   input wire logic [NUM_BRG-1:0]  rate_gen_oe
);
   logic [DATA_W-1:0] ctrl_reg;
   logic [DATA_W-1:0] mask_reg;
   logic              tog_reg;
   logic [3:0]        ga_reg;
   logic [3:0]        gb_reg;

   // Shadows of written registers; cycles a gated timer has been held
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= 16'h0;
         mask_reg <= 16'h0;
         tog_reg  <= 1'b0;
         ga_reg   <= 4'h0;
         gb_reg   <= 4'h0;
      end else begin
         if (wr && addr == CTRL_OFS) ctrl_reg <= wdata;
         if (wr && addr == MASK_OFS) mask_reg <= wdata;
         if (wr && addr == TMODE_OFS) tog_reg <= wdata[MODE_TOGGLE];
         ga_reg <= (gate_a_pin && ctrl_reg[CTRL_GATE_LSB]) ? ga_reg + 4'(ga_reg != 4'h8) : 4'h0;
         gb_reg <= (gate_b_pin && ctrl_reg[CTRL_GATE_LSB+2]) ? gb_reg + 4'(gb_reg != 4'h8) : 4'h0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pulse_one_cycle: assert property (!tog_reg && !$past(tog_reg) && $fell(timer_one_output) |=> timer_one_output)
      else $error("pulse output not one cycle low");
   a_oe_follows: assert property (wr && addr == CTRL_OFS |=> rate_gen_oe == $past(wdata[15:8]))
      else $error("output enables differ from control write");
   a_oe_holds: assert property (!(wr && addr == CTRL_OFS) |=> $stable(rate_gen_oe))
      else $error("output enables changed without a write");
   a_rdata_quiet: assert property (!rd |=> rdata == 16'h0)
      else $error("read data outside read cycle");
   a_irq_masked: assert property (mask_reg == 16'h0 && $past(mask_reg) == 16'h0 |-> !irq)
      else $error("interrupt with all events masked");
   a_irq_cause: assert property ($rose(irq) |-> mask_reg != 16'h0)
      else $error("interrupt rose with empty mask");
   a_gate_a_holds: assert property (ga_reg == 4'h8 |-> $stable(timer_one_output))
      else $error("timer one moved while gated off");
   a_gate_b_holds: assert property (gb_reg == 4'h8 |-> $stable(timer_three_output))
      else $error("timer three moved while gated off");

   c_pulse: cover property ($fell(timer_one_output));
   c_gated: cover property (gb_reg == 4'h8);
   c_irq: cover property ($rose(irq));
endmodule : quad_timer_monitor

bind quad_timer quad_timer_monitor mon (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .irq(irq), .gate_a_pin(gate_a_pin), .gate_b_pin(gate_b_pin),
   .timer_one_output(timer_one_output), .timer_three_output(timer_three_output), .rate_gen_oe(rate_gen_oe));

// file: tb/tb_quad_timer.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
// *****
// Bench
// *****
module tb_quad_timer
   import quad_timer_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h0;
   logic [DATA_W-1:0] wdata = 16'h0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata, rd_val, c;
   logic              irq;
   logic [3:0]        tin = 4'h0;
   logic              gate_a = 1'b1;
   logic              gate_b = 1'b1;
   logic [3:0]        tout;
   logic [10:0]       run = 11'h0;
   logic [9:0]        ext_clk;
   logic              tm_clk;
   logic [7:0]        rg_out, rg_oe;
   int                fail_count = 0;
   int                n_compared = 0;
   int                cycles = 0;

   quad_timer dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .timer_one_input(tin[0]), .timer_two_input(tin[1]), .timer_three_input(tin[2]), .timer_four_input(tin[3]),
      .gate_a_pin(gate_a), .gate_b_pin(gate_b), .timer_one_output(tout[0]), .timer_two_output(tout[1]),
      .timer_three_output(tout[2]), .timer_four_output(tout[3]), .ext_clock_pins(ext_clk),
      .dedicated_timer_clock_pin(tm_clk), .rate_gen_out(rg_out), .rate_gen_oe(rg_oe));
   ext_clock_source pins (.clk(clk), .run(run), .ext_clock_pins(ext_clk), .dedicated_timer_clock_pin(tm_clk));

   always #25 clk = ~clk;
   always @(posedge clk) if (++cycles == 6000) begin
      fail_count++;
      test_done();
   end

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 rd_val = rdata;
   endtask : rreg
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // Cycles between two falls of one timer output
   task automatic period(input int i, input int e);
      int n;
      n = 0;
      for (int k = 0; k < 4; k++) begin
         while (tout[i] !== (k % 2 == 0) && n < 200) begin
            cyc(1);
            n++;
         end
         if (k == 1) n = 0;
      end
      `CHK("period", e, n)
   endtask : period
   task automatic system_integration_unit(input logic e);
      cyc(4);
      rreg(SIUCNT_OFS);
      c = rd_val;
      cyc(20);
      rreg(SIUCNT_OFS);
      `CHK("siu moves", e, rd_val !== c)
   endtask : system_integration_unit

   task automatic t_timers();
      `CHK("idle out", 4'hf, tout)
      wreg(MASK_OFS, 16'h0001);
      wreg(TREF_OFS, 16'h0001);
      wreg(TMODE_OFS, 16'h0089);
      period(0, 2);
      `CHK("irq", 1'b1, irq)
      rreg(STAT_OFS);
      `CHK("match", 1'b1, rd_val[STAT_MATCH_LSB])
      wreg(MASK_OFS, 16'h0000);
      wreg(TMODE_OFS, 16'h008d);
      wreg(TREF_OFS + 8'h04, 16'h0001);
      wreg(TMODE_OFS + 8'h04, 16'h008c);
      wreg(TMODE_OFS + 8'h0c, 16'h008a);
      period(0, 4);
      period(1, 8);
      period(3, 16);
   endtask : t_timers
   task automatic t_capture();
      for (int m = 1; m < 4; m++) begin
         wreg(TMODE_OFS + 8'h08, {8'h00, 2'b10, m[1:0], 4'h3});
         rreg(STAT_OFS);
         @(posedge clk);
         tin[2] <= 1'b1;
         cyc(6);
         rreg(STAT_OFS);
         `CHK("rise capture", m[0], rd_val[STAT_CAP_LSB+2])
         @(posedge clk);
         tin[2] <= 1'b0;
         cyc(6);
         rreg(STAT_OFS);
         `CHK("fall capture", m[1], rd_val[STAT_CAP_LSB+2])
      end
   endtask : t_capture
   task automatic t_gate();
      wreg(TMODE_OFS, 16'h0089);
      wreg(TREF_OFS + 8'h08, 16'h00ff);
      wreg(TMODE_OFS + 8'h08, 16'h00c9);
      cyc(40);
      wreg(CTRL_OFS, 16'h0014);
      cyc(10);
      rreg(TCNT_OFS + 8'h08);
      c = rd_val;
      @(posedge clk);
      gate_a <= 1'b0;
      period(0, 2);
      rreg(TCNT_OFS + 8'h08);
      `CHK("gate b holds", c, rd_val)
      @(posedge clk);
      gate_b <= 1'b0;
      // Gate edge reaches the counter only after the two sync stages
      cyc(4);
      rreg(TCNT_OFS + 8'h08);
      `CHK("restart", 1'b1, rd_val < 16'h0010)
   endtask : t_gate
   task automatic t_clocks();
      wreg(CTRL_OFS, 16'hff00);
      #1;
      `CHK("oe", 8'hff, rg_oe)
      system_integration_unit(1'b1);
      wreg(CTRL_OFS, 16'hff01);
      system_integration_unit(1'b0);
      run[4] <= 1'b1;
      system_integration_unit(1'b1);
      wreg(CTRL_OFS, 16'hff03);
      system_integration_unit(1'b0);
      run[10] <= 1'b1;
      system_integration_unit(1'b1);
      wreg(BRG_OFS + 8'h0c, 16'ha000);
      run[9] <= 1'b1;
      cyc(8);
      c[0] = rg_out[3];
      cyc(8);
      `CHK("gen four", ~c[0], rg_out[3])
   endtask : t_clocks

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_timers();
      t_capture();
      t_gate();
      t_clocks();
      test_done();
   end
endmodule : tb_quad_timer
